// File: logic/dsm_top.sv
// Control logic around the primary and secondary supply comparators,
// with an AXI4-Lite register slave.
// Assumes comparator outputs are asynchronous levels, high while the
// supply is below the threshold, and RESET_N is the power-on reset.
`include "dsm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module dsm_top
   import dsm_pkg::*;
#(
   parameter int STAB_CYCLES = `DSM_STAB_US * `DSM_CLK_MHZ
)(
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   input  wire logic        CLK_EN,
   input  wire logic        PRIMARY_BELOW,
   input  wire logic        SECONDARY_BELOW,
   input  wire logic        PRIMARY_MODE_STRAP,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   output logic [1:0]       S_AXI_BRESP,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             CPU_RESET_N,
   output logic             LOW_VOLTAGE_IRQ,
   output logic             SECONDARY_MONITOR_ENABLE,
   output logic [4:0]       SECONDARY_THRESHOLD
);

   function automatic logic dsm_mapped(input logic [7:0] addr);
      logic [7:0] a;
      a = {addr[7:2], 2'b00};
      return (a == `DSM_OFF_CTRL) || (a == `DSM_OFF_CFG) ||
             (a == `DSM_OFF_STAT) || (a == `DSM_OFF_CLR) ||
             (a == `DSM_OFF_CAUSE) || (a == `DSM_OFF_PORC);
   endfunction : dsm_mapped

   // Synchroniser stages; the first stage feeds only the second.
   logic prim_s1_r, prim_s2_r, sec_s1_r, sec_s2_r;

   logic           por_hold_r, por_hold_nxt;
   logic           strap_done_r, strap_done_nxt;
   logic           pmode_r, pmode_nxt;
   logic           prim_prev_r, prim_prev_nxt;
   logic           sec_prev_r, sec_prev_nxt;
   dsm_sec_state_t sec_state_r, sec_state_nxt;
   logic [15:0]    stab_cnt_r, stab_cnt_nxt;
   logic           armed_r, armed_nxt;
   logic [3:0]     rst_cnt_r, rst_cnt_nxt;
   dsm_cfg_t       cfg_r, cfg_nxt;
   logic           rwe_r, rwe_nxt;
   logic           pflag_r, pflag_nxt;
   logic           sflag_r, sflag_nxt;
   dsm_cause_t     cause_r, cause_nxt;
   logic           porc_r, porc_nxt;
   logic           irq_r, irq_nxt;
   logic           cpu_rst_n_r, cpu_rst_n_nxt;

   logic        aw_got_r, aw_got_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic        w_got_r, w_got_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic        w_strb0_r, w_strb0_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;

   logic        prim_low, sec_low, sec_active;
   logic        prim_hold, sec_fire, sw_fire, wipe;
   logic        prim_ev, sec_ev, pclr, sclr;
   logic        wr_en;
   logic [7:0]  wr_addr;

   assign prim_low   = prim_s2_r;
   assign sec_low    = sec_s2_r;
   assign sec_active = (sec_state_r == DSM_SEC_ACTIVE);
   assign wr_en      = aw_got_r && w_got_r && !bvalid_r && w_strb0_r;
   assign wr_addr    = {aw_addr_r[7:2], 2'b00};

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prim_s1_r <= 1'b1;
         prim_s2_r <= 1'b1;
         sec_s1_r  <= 1'b0;
         sec_s2_r  <= 1'b0;
      end else if (CLK_EN) begin
         prim_s1_r <= PRIMARY_BELOW;
         prim_s2_r <= prim_s1_r;
         sec_s1_r  <= SECONDARY_BELOW;
         sec_s2_r  <= sec_s1_r;
      end
   end

   always_comb begin
      pclr = 1'b0;
      sclr = 1'b0;
      sw_fire = 1'b0;
      por_hold_nxt   = por_hold_r && prim_low;
      strap_done_nxt = 1'b1;
      pmode_nxt      = strap_done_r ? pmode_r : PRIMARY_MODE_STRAP;
      prim_prev_nxt  = prim_low;
      sec_prev_nxt   = sec_low;
      cfg_nxt        = cfg_r;
      rwe_nxt        = rwe_r;
      cause_nxt      = cause_r;
      porc_nxt       = porc_r;
      prim_hold = !por_hold_r && strap_done_r && pmode_r && prim_low;
      sec_fire  = sec_active && cfg_r.rst_mode && sec_low &&
                  (rst_cnt_r == 4'h0);
      prim_ev = !por_hold_r && strap_done_r && !pmode_r &&
                (prim_low != prim_prev_r);
      // Unarmed, only a low level counts, so a rise seen first is dropped.
      sec_ev = sec_active && !cfg_r.rst_mode &&
               (armed_r ? (sec_low != sec_prev_r) : sec_low);
      if (wr_en) begin
         unique case (wr_addr)
            `DSM_OFF_CTRL: begin
               rwe_nxt = w_data_r[`DSM_CTRL_RWE];
               sw_fire = w_data_r[`DSM_CTRL_SWRST];
            end
            `DSM_OFF_CFG: begin
               if (rwe_r) begin
                  cfg_nxt = w_data_r[`DSM_CFG_LVL_HI:`DSM_CFG_EN];
               end
            end
            `DSM_OFF_CLR: begin
               pclr = w_data_r[`DSM_CLR_PEV];
               sclr = w_data_r[`DSM_CLR_SEV];
            end
            `DSM_OFF_CAUSE: begin
               cause_nxt = cause_r & ~w_data_r[2:0];
            end
            `DSM_OFF_PORC: begin
               porc_nxt = porc_r && !w_data_r[0];
            end
            default: begin
            end
         endcase
      end
      if (sec_fire) begin
         pmode_nxt = 1'b1;
      end
      wipe = sec_fire || sw_fire || prim_hold;
      // The record names only the latest reset, so it is replaced.
      if (prim_hold) begin
         cause_nxt = 3'b001;
         porc_nxt  = 1'b0;
      end else if (sec_fire) begin
         cause_nxt = 3'b010;
         porc_nxt  = 1'b0;
      end else if (sw_fire) begin
         cause_nxt = 3'b100;
         porc_nxt  = 1'b0;
      end
      if (sec_fire || sw_fire) begin
         rst_cnt_nxt = `DSM_RST_PULSE;
      end else if (rst_cnt_r != 4'h0) begin
         rst_cnt_nxt = rst_cnt_r - 4'h1;
      end else begin
         rst_cnt_nxt = 4'h0;
      end
      if (wipe) begin
         cfg_nxt = `DSM_CFG_RST;
         rwe_nxt = 1'b0;
      end
      cpu_rst_n_nxt = !(por_hold_nxt || prim_hold ||
                        (rst_cnt_nxt != 4'h0));
   end

   always_comb begin
      sec_state_nxt = sec_state_r;
      stab_cnt_nxt  = stab_cnt_r;
      armed_nxt     = armed_r;
      if (!cfg_nxt.enable) begin
         sec_state_nxt = DSM_SEC_OFF;
      end else begin
         unique case (sec_state_r)
            DSM_SEC_OFF: begin
               sec_state_nxt = DSM_SEC_WAIT;
               stab_cnt_nxt  = 16'h0000;
            end
            DSM_SEC_WAIT: begin
               if (stab_cnt_r == 16'(STAB_CYCLES - 1)) begin
                  sec_state_nxt = DSM_SEC_ACTIVE;
                  armed_nxt     = 1'b0;
               end else begin
                  stab_cnt_nxt = stab_cnt_r + 16'h0001;
               end
            end
            DSM_SEC_ACTIVE: begin
               if (sec_ev) begin
                  armed_nxt = 1'b1;
               end
            end
            default: begin
               sec_state_nxt = DSM_SEC_OFF;
            end
         endcase
      end
   end

   always_comb begin
      // Set wins over a software clear so no event is lost.
      pflag_nxt = prim_ev || (pflag_r && !pclr);
      sflag_nxt = sec_ev || (sflag_r && !sclr);
      irq_nxt   = (prim_ev || sec_ev) && !wipe;
      if (wipe) begin
         pflag_nxt = 1'b0;
         sflag_nxt = 1'b0;
      end
   end

   assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
   assign S_AXI_WREADY  = !w_got_r && !bvalid_r;
   assign S_AXI_ARREADY = !rvalid_r;

   always_comb begin
      aw_got_nxt  = aw_got_r;
      aw_addr_nxt = aw_addr_r;
      w_got_nxt   = w_got_r;
      w_data_nxt  = w_data_r;
      w_strb0_nxt = w_strb0_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_got_nxt  = 1'b1;
         aw_addr_nxt = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_got_nxt   = 1'b1;
         w_data_nxt  = S_AXI_WDATA;
         w_strb0_nxt = S_AXI_WSTRB[0];
      end
      if (aw_got_r && w_got_r && !bvalid_r) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = dsm_mapped(aw_addr_r) ? `DSM_RESP_OKAY
                                            : `DSM_RESP_SLV;
      end else if (bvalid_r && S_AXI_BREADY) begin
         bvalid_nxt = 1'b0;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = 32'h0000_0000;
         rresp_nxt  = dsm_mapped(S_AXI_ARADDR) ? `DSM_RESP_OKAY
                                               : `DSM_RESP_SLV;
         unique case ({S_AXI_ARADDR[7:2], 2'b00})
            `DSM_OFF_CTRL: begin
               rdata_nxt[`DSM_CTRL_RWE]   = rwe_r;
               rdata_nxt[`DSM_CTRL_PMODE] = pmode_r;
               rdata_nxt[`DSM_CTRL_SACT]  = sec_active;
            end
            `DSM_OFF_CFG: begin
               rdata_nxt[`DSM_CFG_LVL_HI:`DSM_CFG_EN] = cfg_r;
            end
            `DSM_OFF_STAT: begin
               rdata_nxt[`DSM_STAT_PEV]  = pflag_r;
               rdata_nxt[`DSM_STAT_SEV]  = sflag_r;
               rdata_nxt[`DSM_STAT_PLVL] = prim_low;
               rdata_nxt[`DSM_STAT_SLVL] = sec_low && sec_active;
            end
            `DSM_OFF_CAUSE: begin
               rdata_nxt[2:0] = cause_r;
            end
            `DSM_OFF_PORC: begin
               rdata_nxt[0] = porc_r;
            end
            default: begin
            end
         endcase
      end else if (rvalid_r && S_AXI_RREADY) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         por_hold_r   <= 1'b1;
         strap_done_r <= 1'b0;
         pmode_r      <= 1'b1;
         prim_prev_r  <= 1'b1;
         sec_prev_r   <= 1'b0;
         sec_state_r  <= DSM_SEC_OFF;
         stab_cnt_r   <= 16'h0000;
         armed_r      <= 1'b0;
         rst_cnt_r    <= 4'h0;
         cfg_r        <= `DSM_CFG_RST;
         rwe_r        <= 1'b0;
         pflag_r      <= 1'b0;
         sflag_r      <= 1'b0;
         cause_r      <= 3'b000;
         porc_r       <= 1'b1;
         irq_r        <= 1'b0;
         cpu_rst_n_r  <= 1'b0;
         aw_got_r     <= 1'b0;
         aw_addr_r    <= 8'h00;
         w_got_r      <= 1'b0;
         w_data_r     <= 32'h0000_0000;
         w_strb0_r    <= 1'b0;
         bvalid_r     <= 1'b0;
         bresp_r      <= `DSM_RESP_OKAY;
         rvalid_r     <= 1'b0;
         rdata_r      <= 32'h0000_0000;
         rresp_r      <= `DSM_RESP_OKAY;
      end else if (CLK_EN) begin
         por_hold_r   <= por_hold_nxt;
         strap_done_r <= strap_done_nxt;
         pmode_r      <= pmode_nxt;
         prim_prev_r  <= prim_prev_nxt;
         sec_prev_r   <= sec_prev_nxt;
         sec_state_r  <= sec_state_nxt;
         stab_cnt_r   <= stab_cnt_nxt;
         armed_r      <= armed_nxt;
         rst_cnt_r    <= rst_cnt_nxt;
         cfg_r        <= cfg_nxt;
         rwe_r        <= rwe_nxt;
         pflag_r      <= pflag_nxt;
         sflag_r      <= sflag_nxt;
         cause_r      <= cause_nxt;
         porc_r       <= porc_nxt;
         irq_r        <= irq_nxt;
         cpu_rst_n_r  <= cpu_rst_n_nxt;
         aw_got_r     <= aw_got_nxt;
         aw_addr_r    <= aw_addr_nxt;
         w_got_r      <= w_got_nxt;
         w_data_r     <= w_data_nxt;
         w_strb0_r    <= w_strb0_nxt;
         bvalid_r     <= bvalid_nxt;
         bresp_r      <= bresp_nxt;
         rvalid_r     <= rvalid_nxt;
         rdata_r      <= rdata_nxt;
         rresp_r      <= rresp_nxt;
      end
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP  = bresp_r;
   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA  = rdata_r;
   assign S_AXI_RRESP  = rresp_r;
   assign CPU_RESET_N     = cpu_rst_n_r;
   assign LOW_VOLTAGE_IRQ = irq_r;
   assign SECONDARY_MONITOR_ENABLE = cfg_r.enable;
   assign SECONDARY_THRESHOLD      = cfg_r.level;

endmodule : dsm_top

`default_nettype wire

// File: inc/dsm_consts.svh
// Offsets, field positions, reset values and timing figures of the
// dual supply monitor control block.
// Assumes inclusion by bare name from the design files.
`ifndef DSM_CONSTS_SVH
`define DSM_CONSTS_SVH

`define DSM_OFF_CTRL   8'h00
`define DSM_OFF_CFG    8'h04
`define DSM_OFF_STAT   8'h08
`define DSM_OFF_CLR    8'h0c
`define DSM_OFF_CAUSE  8'h10
`define DSM_OFF_PORC   8'h14

`define DSM_CTRL_RWE   0
`define DSM_CTRL_PMODE 1
`define DSM_CTRL_SACT  2
`define DSM_CTRL_SWRST 3

`define DSM_CFG_EN     0
`define DSM_CFG_MODE   1
`define DSM_CFG_LVL_LO 2
`define DSM_CFG_LVL_HI 6

`define DSM_STAT_PEV   0
`define DSM_STAT_SEV   1
`define DSM_STAT_PLVL  2
`define DSM_STAT_SLVL  3

`define DSM_CLR_PEV    0
`define DSM_CLR_SEV    1

`define DSM_CAUSE_PRIM 0
`define DSM_CAUSE_SEC  1
`define DSM_CAUSE_SW   2

`define DSM_CFG_RST    7'h00
`define DSM_RESP_OKAY  2'h0
`define DSM_RESP_SLV   2'h2

`define DSM_STAB_US    500
`define DSM_CLK_MHZ    100
`define DSM_RST_PULSE  4'h8

`endif

// File: inc/dsm_pkg.sv
// Types shared by the dual supply monitor control block.
// Assumes nothing of its surroundings.
package dsm_pkg;

   typedef enum logic [1:0] {
      DSM_SEC_OFF    = 2'b00,
      DSM_SEC_WAIT   = 2'b01,
      DSM_SEC_ACTIVE = 2'b11
   } dsm_sec_state_t;

   typedef struct packed {
      logic [4:0] level;
      logic       rst_mode;
      logic       enable;
   } dsm_cfg_t;

   typedef struct packed {
      logic sw;
      logic sec;
      logic prim;
   } dsm_cause_t;

endpackage : dsm_pkg

// File: test/dsm_top_monitor.sv
// Concurrent checks on the ports of the dual supply monitor control block.
// Assumes CLK_EN stays high and the secondary monitor is activated only
// while its comparator reports the supply good.
`timescale 1ns/1ns
`default_nettype none

module dsm_top_monitor (
   input wire logic        MCLK,
   input wire logic        RESET_N,
   input wire logic        PRIMARY_BELOW,
   input wire logic        SECONDARY_BELOW,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        CPU_RESET_N,
   input wire logic        LOW_VOLTAGE_IRQ,
   input wire logic        SECONDARY_MONITOR_ENABLE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   // Cycles since a comparator input last moved; an interrupt outside a
   // short window after a move has no cause at the pins.
   logic       prim_q;
   logic       sec_q;
   logic [2:0] age;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         prim_q <= 1'b1;
         sec_q <= 1'b0;
         age <= 3'h7;
      end else begin
         prim_q <= PRIMARY_BELOW;
         sec_q <= SECONDARY_BELOW;
         if (PRIMARY_BELOW != prim_q || SECONDARY_BELOW != sec_q) begin
            age <= 3'h0;
         end else if (age != 3'h7) begin
            age <= age + 3'h1;
         end
      end
   end

   property p_release;
      $rose(CPU_RESET_N) |-> !$past(PRIMARY_BELOW, 3);
   endproperty
   a_release: assert property (p_release)
      else $error("processor released while supply was low");
   property p_cause;
      LOW_VOLTAGE_IRQ |-> age inside {[3'h1:3'h3]};
   endproperty
   a_cause: assert property (p_cause)
      else $error("interrupt without a synchronised crossing");
   property p_pulse;
      LOW_VOLTAGE_IRQ |=> !LOW_VOLTAGE_IRQ;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("interrupt longer than one cycle");
   property p_cfg_clear;
      $fell(CPU_RESET_N) |-> ##[0:2] !SECONDARY_MONITOR_ENABLE;
   endproperty
   a_cfg_clear: assert property (p_cfg_clear)
      else $error("secondary stays enabled across a reset");
   property p_b_stand;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_b_stand: assert property (p_b_stand)
      else $error("write response dropped before taken");
   property p_r_stand;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_r_stand: assert property (p_r_stand)
      else $error("read data changed before taken");
   property p_w_refuse;
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
   endproperty
   a_w_refuse: assert property (p_w_refuse)
      else $error("write accepted while a response waits");
   property p_r_latency;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY;
   endproperty
   a_r_latency: assert property (p_r_latency)
      else $error("read answer not one cycle after address");
endmodule : dsm_top_monitor

bind dsm_top dsm_top_monitor u_mon (
   .MCLK(MCLK), .RESET_N(RESET_N), .PRIMARY_BELOW(PRIMARY_BELOW),
   .SECONDARY_BELOW(SECONDARY_BELOW), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .CPU_RESET_N(CPU_RESET_N),
   .LOW_VOLTAGE_IRQ(LOW_VOLTAGE_IRQ),
   .SECONDARY_MONITOR_ENABLE(SECONDARY_MONITOR_ENABLE));

`default_nettype wire

// File: test/tb_dsm_top.sv
// Self-checking bench for the dual supply monitor control block.
// Assumes the package, constants header and checker are compiled first.
`include "dsm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_dsm_top;
   localparam logic [1:0] OK = `DSM_RESP_OKAY;
   logic        clk, rst_n, pb, sb, awv, wv, bready, arv, rready, strap;
   logic        awrdy, wrdy, bv, arrdy, rv, cpu_n, irq, sen;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, seed, r;
   logic [1:0]  bresp, rresp;
   logic [4:0]  sthr, lvl;
   int          fail_count, checked, irq_n, m_irq;

   dsm_top #(.STAB_CYCLES(40)) u_dut (
      .MCLK(clk), .RESET_N(rst_n), .CLK_EN(1'b1), .PRIMARY_BELOW(pb),
      .SECONDARY_BELOW(sb), .PRIMARY_MODE_STRAP(strap),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_AWADDR(awaddr),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
      .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
      .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .CPU_RESET_N(cpu_n),
      .LOW_VOLTAGE_IRQ(irq), .SECONDARY_MONITOR_ENABLE(sen),
      .SECONDARY_THRESHOLD(sthr));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (irq === 1'b1) irq_n <= irq_n + 1;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk

   task automatic hang();
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
   endtask : hang

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // A write offers address and data together; each is dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awv <= 1'b1;
      awaddr <= a;
      wv <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awrdy) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
         n++;
      end while (!bv && n < 100);
      if (!bv) hang();
      chk(32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      arv <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arrdy) arv <= 1'b0;
         n++;
      end while (!rv && n < 100);
      if (!rv) hang();
      chk(rdata, exp);
      chk(32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask : rd

   task automatic wait_cpu(input logic v);
      int n;
      n = 0;
      while (cpu_n !== v && n < 200) begin
         @(posedge clk);
         n++;
      end
      if (cpu_n !== v) hang();
   endtask : wait_cpu

   // Drives both comparator inputs on the same edge, then lets the synchroniser settle.
   task automatic setcmp(input logic p, input logic s);
      @(posedge clk);
      pb <= p;
      sb <= s;
      cyc(6);
   endtask : setcmp

   task automatic enable_sec(input logic rst_mode);
      wr(`DSM_OFF_CTRL, 32'h1, OK);
      wr(`DSM_OFF_CFG, {25'h0, lvl, rst_mode, 1'b1}, OK);
      wr(`DSM_OFF_CTRL, 32'h0, OK);
   endtask : enable_sec

   initial begin
      {rst_n, sb, awv, wv, bready, arv, rready, strap} = '0;
      {awaddr, araddr, wdata} = '0;
      pb = 1'b1;
      seed = 32'h0000ac82;
      cyc(16);
      rst_n <= 1'b1;
      cyc(10);
      chk(32'(cpu_n), 32'h0);
      setcmp(1'b0, 1'b0);
      wait_cpu(1'b1);
      rd(`DSM_OFF_PORC, 32'h1, OK);
      for (int i = 0; i < 2; i++) begin
         setcmp(~i[0], 1'b0);
         m_irq++;
         chk(irq_n, m_irq);
         rd(`DSM_OFF_STAT, {29'h0, ~i[0], 2'b01}, OK);
         wr(`DSM_OFF_CLR, 32'h1, OK);
         rd(`DSM_OFF_STAT, {29'h0, ~i[0], 2'b00}, OK);
      end
      r = xs();
      lvl = r[4:0];
      wr(`DSM_OFF_CFG, {25'h0, lvl, 2'b01}, OK);
      chk(32'(sen), 32'h0);
      enable_sec(1'b0);
      chk(32'({sen, sthr}), 32'({1'b1, lvl}));
      rd(`DSM_OFF_CTRL, 32'h0, OK);
      cyc(50);
      rd(`DSM_OFF_CTRL, 32'h4, OK);
      chk(irq_n, m_irq);
      setcmp(1'b0, 1'b1);
      m_irq++;
      chk(irq_n, m_irq);
      rd(`DSM_OFF_STAT, 32'ha, OK);
      wr(`DSM_OFF_CLR, 32'h2, OK);
      setcmp(1'b0, 1'b0);
      m_irq++;
      chk(irq_n, m_irq);
      rd(`DSM_OFF_STAT, 32'h2, OK);
      wr(`DSM_OFF_CLR, 32'h2, OK);
      rd(`DSM_OFF_STAT, 32'h0, OK);
      r = xs();
      wr(8'h40, r, `DSM_RESP_SLV);
      rd(8'h40, 32'h0, `DSM_RESP_SLV);
      for (int i = 0; i < 2; i++) begin
         enable_sec(1'b1);
         if (i == 0) begin
            cyc(60);
            chk(32'(cpu_n), 32'h1);
            setcmp(1'b0, 1'b1);
         end
         wait_cpu(1'b0);
         wait_cpu(1'b1);
         chk(32'(sen), 32'h0);
         rd(`DSM_OFF_CAUSE, 32'h2, OK);
         rd(`DSM_OFF_CTRL, 32'h2, OK);
      end
      rd(`DSM_OFF_PORC, 32'h0, OK);
      setcmp(1'b0, 1'b0);
      setcmp(1'b1, 1'b0);
      cyc(20);
      chk(32'(cpu_n), 32'h0);
      setcmp(1'b0, 1'b0);
      wait_cpu(1'b1);
      rd(`DSM_OFF_CAUSE, 32'h1, OK);
      wr(`DSM_OFF_CTRL, 32'h8, OK);
      wait_cpu(1'b0);
      wait_cpu(1'b1);
      rd(`DSM_OFF_CAUSE, 32'h4, OK);
      wr(`DSM_OFF_CAUSE, 32'h7, OK);
      rd(`DSM_OFF_CAUSE, 32'h0, OK);
      // A second power-on reset with the strap set selects reset mode.
      @(posedge clk);
      rst_n <= 1'b0;
      strap <= 1'b1;
      pb <= 1'b1;
      cyc(16);
      rst_n <= 1'b1;
      cyc(10);
      chk(32'(cpu_n), 32'h0);
      chk(32'(sen), 32'h0);
      setcmp(1'b0, 1'b0);
      wait_cpu(1'b1);
      rd(`DSM_OFF_CTRL, 32'h2, OK);
      rd(`DSM_OFF_PORC, 32'h1, OK);
      rd(`DSM_OFF_CAUSE, 32'h0, OK);
      chk(irq_n, m_irq);
      final_report();
   end

   initial begin
      cyc(100000);
      hang();
   end
endmodule : tb_dsm_top

`default_nettype wire
